// *** shared/charger_pkg.sv ***
// constants for the charger pin control logic
`default_nettype none
package charger_pkg;
	// clock rate
	localparam int CLK_HZ             = 50_000_000;
	localparam int CLK_PER_MS         = CLK_HZ / 1000;
	// timing figures in their own units
	localparam int ALERT_US           = 256;
	localparam int BLINK_HZ           = 1;
	localparam int SHIP_EXIT_MS       = 1000;
	localparam int SYS_RESET_MS       = 8000;
	localparam int SWITCH_OFF_MS      = 250;
	// derived cycle counts
	localparam int ALERT_CYCLES       = ALERT_US * (CLK_HZ / 1_000_000);
	localparam int BLINK_HALF_CYCLES  = CLK_HZ / (2 * BLINK_HZ);
	localparam int SHIP_EXIT_CYCLES   = SHIP_EXIT_MS * CLK_PER_MS;
	localparam int SYS_RESET_CYCLES   = SYS_RESET_MS * CLK_PER_MS;
	localparam int SWITCH_OFF_CYCLES  = SWITCH_OFF_MS * CLK_PER_MS;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL     = 5'h00;
	localparam logic [4:0] OFS_LIMIT    = 5'h04;
	localparam logic [4:0] OFS_DRIVE    = 5'h08;
	localparam logic [4:0] OFS_STATUS   = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
	// control register bit positions
	localparam int CTRL_CHARGE_BIT    = 0;
	localparam int CTRL_BOOST_BIT     = 1;
	localparam int CTRL_LIMPIN_BIT    = 2;
	localparam int CTRL_SHIP_BIT      = 3;
	// drive register field positions
	localparam int DRIVE_DPLUS_LSB    = 0;
	localparam int DRIVE_DMINUS_LSB   = 4;
	// status register field positions
	localparam int STAT_DET_LSB       = 4;
	localparam int STAT_LIMIT_LSB     = 16;
	// interrupt event bits
	localparam int IRQ_W              = 5;
	localparam int EV_STATUS          = 0;
	localparam int EV_FAULT           = 1;
	localparam int EV_DONE            = 2;
	localparam int EV_DETECT          = 3;
	localparam int EV_SYSRST          = 4;
	// reset values
	localparam logic [3:0] CTRL_RESET    = 4'h5;
	localparam logic [5:0] LIMIT_RESET   = 6'h0A;
	localparam logic [2:0] DRIVE_RESET   = 3'h0;
	localparam logic [IRQ_W-1:0] MASK_RESET = 5'h00;
	// input limit code in 50 mA steps, pin floor of 500 mA
	localparam logic [5:0] PIN_LIMIT_MIN = 6'h0A;
	// detected port kinds
	localparam logic [2:0] KIND_SDP   = 3'h0;
	localparam logic [2:0] KIND_CDP   = 3'h1;
	localparam logic [2:0] KIND_DCP   = 3'h2;
	localparam logic [2:0] KIND_HV_DCP = 3'h3;
	// detection sequence states, gray along the path
	typedef enum logic [2:0] {
		DET_IDLE = 3'h0,
		DET_DCD  = 3'h1,
		DET_PRI  = 3'h3,
		DET_SEC  = 3'h2,
		DET_HV   = 3'h6,
		DET_DONE = 3'h7
	} det_state_t;
endpackage
`default_nettype wire

// *** src/charger_pin_ctrl.sv ***
// pin level control logic of a single cell charger
`timescale 1ns/1ns
`default_nettype none
// Contract
// - status pin held low throughout a charge cycle
// - status pin released when done, asleep or charging disabled
// - fault suspend blinks status pin at 1 Hz, equal halves
// - alert pin pulses low 256 us per status change or fault
// - boost runs only when boost bit set and boost pin high
// - charging only when charge bit set and charge pin low
// - applied input limit is smaller of field and enabled pin limit
// - pin limit ignored while its use bit is clear
// - pin limits under 500 mA are not accepted
// - button low for ship exit time leaves ship mode
// - no supply, button held 8 s: switch off 250 ms
// - mux select low normally, high while detection runs
// - after detection select stays high only for dedicated ports
// - data pins drive only after detection or during boost
// - detection runs contact, primary, secondary, high voltage steps
// - host programs bits and reads status over the register bus
module charger_pin_ctrl #(
	parameter int ALERT_CYCLES      = charger_pkg::ALERT_CYCLES,
	parameter int BLINK_HALF_CYCLES = charger_pkg::BLINK_HALF_CYCLES,
	parameter int SHIP_EXIT_CYCLES  = charger_pkg::SHIP_EXIT_CYCLES,
	parameter int SYS_RESET_CYCLES  = charger_pkg::SYS_RESET_CYCLES,
	parameter int SWITCH_OFF_CYCLES = charger_pkg::SWITCH_OFF_CYCLES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// avalon-mm slave
	input  wire logic [4:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	output logic             irq_o,
	// pins from outside
	input  wire logic        battery_button_n_i,
	input  wire logic        boost_request_pin_i,
	input  wire logic        charge_allow_n_i,
	input  wire logic        vbus_present_i,
	// charger core state, same clock
	input  wire logic        charge_active_i,
	input  wire logic        fault_suspend_i,
	input  wire logic        status_event_i,
	input  wire logic [5:0]  input_limit_pin_i,
	input  wire logic        phase_done_i,
	input  wire logic [2:0]  port_kind_i,
	// open drain outputs, enable pulls low
	output logic             charge_stat_oe_o,
	output logic             alert_oe_o,
	// controls
	output logic             boost_en_o,
	output logic             charge_en_o,
	output logic [5:0]       input_limit_o,
	output logic             battery_switch_o,
	output logic             line_mux_select_o,
	output logic [2:0]       dplus_drive_level_o,
	output logic             dplus_oe_o,
	output logic [2:0]       dminus_drive_level_o,
	output logic             dminus_oe_o
);
	// bit order of synchronised pins
	localparam int PIN_BTN   = 0;
	localparam int PIN_BOOST = 1;
	localparam int PIN_CE    = 2;
	localparam int PIN_VB    = 3;

	logic [3:0]  sync1_reg, sync2_reg, sync3_reg, pin_reg;
	logic [3:0]  ctrl_reg;
	logic [5:0]  input_limit_field_reg;
	logic [2:0]  dplus_level_reg, dminus_level_reg;
	logic [charger_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, ev;
	logic        ack_reg;
	logic        wr_hit, fault_q_reg, vbus_q_reg;
	logic [31:0] blink_cnt_reg, alert_cnt_reg, btn_cnt_reg, off_cnt_reg;
	logic        blink_phase_reg, ship_reg, off_reg, btn_used_reg;
	logic [2:0]  kind_reg;
	charger_pkg::det_state_t det_reg;

	// smaller of two limit codes
	function automatic logic [5:0] min6(input logic [5:0] a,
		input logic [5:0] b);
		min6 = (a < b) ? a : b;
	endfunction

	// three stage synchroniser, change taken when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 4'h5; // idle pin levels, no false edge
			sync2_reg <= 4'h5;
			sync3_reg <= 4'h5;
			pin_reg   <= 4'h5;
		end else begin
			sync1_reg <= {vbus_present_i, charge_allow_n_i,
				boost_request_pin_i, battery_button_n_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg   <= (sync2_reg & sync3_reg) |
				(pin_reg & (sync2_reg | sync3_reg));
		end
	end

	// bus handshake, one wait state per access
	assign wr_hit = write_i && ack_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg       <= 1'b0;
			waitrequest_o <= 1'b1;
		end else begin
			ack_reg       <= (read_i || write_i) && !ack_reg;
			waitrequest_o <= !((read_i || write_i) && !ack_reg);
		end
	end

	// writable configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg              <= charger_pkg::CTRL_RESET;
			input_limit_field_reg <= charger_pkg::LIMIT_RESET;
			dplus_level_reg       <= charger_pkg::DRIVE_RESET;
			dminus_level_reg      <= charger_pkg::DRIVE_RESET;
			irq_mask_reg          <= charger_pkg::MASK_RESET;
		end else if (wr_hit) begin
			case (address_i)
				charger_pkg::OFS_CTRL:
					ctrl_reg <= writedata_i[3:0];
				charger_pkg::OFS_LIMIT:
					input_limit_field_reg <= writedata_i[5:0];
				charger_pkg::OFS_DRIVE: begin
					dplus_level_reg  <=
						writedata_i[charger_pkg::DRIVE_DPLUS_LSB +: 3];
					dminus_level_reg <=
						writedata_i[charger_pkg::DRIVE_DMINUS_LSB +: 3];
				end
				charger_pkg::OFS_IRQ_MASK:
					irq_mask_reg <= writedata_i[charger_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// read data, registered on the first cycle of an access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readdata_o <= 32'h0;
		end else if (read_i && !ack_reg) begin
			case (address_i)
				charger_pkg::OFS_CTRL:
					readdata_o <= {28'h0, ship_reg, ctrl_reg[2:0]};
				charger_pkg::OFS_LIMIT:
					readdata_o <= {26'h0, input_limit_field_reg};
				charger_pkg::OFS_DRIVE:
					readdata_o <= {25'h0, dminus_level_reg, 1'b0,
						dplus_level_reg};
				charger_pkg::OFS_STATUS:
					readdata_o <= {10'h0, input_limit_o, 8'h0, 1'b0,
						det_reg, line_mux_select_o, battery_switch_o,
						boost_en_o, charge_en_o};
				charger_pkg::OFS_IRQ_STAT:
					readdata_o <= {27'h0, irq_stat_reg};
				charger_pkg::OFS_IRQ_MASK:
					readdata_o <= {27'h0, irq_mask_reg};
				default:
					readdata_o <= 32'h0;
			endcase
		end
	end

	// event sources
	always_comb begin
		ev = '0;
		ev[charger_pkg::EV_STATUS] = status_event_i;
		ev[charger_pkg::EV_FAULT]  = fault_suspend_i && !fault_q_reg;
		ev[charger_pkg::EV_DONE]   = !charge_active_i && charge_en_o &&
			!fault_suspend_i && charge_stat_oe_o && !fault_q_reg;
		ev[charger_pkg::EV_DETECT] = (det_reg == charger_pkg::DET_HV) &&
			phase_done_i;
		ev[charger_pkg::EV_SYSRST] = !pin_reg[PIN_VB] && !btn_used_reg &&
			!pin_reg[PIN_BTN] && !ship_reg &&
			(btn_cnt_reg >= 32'(SYS_RESET_CYCLES - 1));
	end

	// sticky status, write one clears, a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_o        <= 1'b0;
			fault_q_reg  <= 1'b0;
		end else begin
			if (wr_hit && address_i == charger_pkg::OFS_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg &
					~writedata_i[charger_pkg::IRQ_W-1:0]) | ev;
			else
				irq_stat_reg <= irq_stat_reg | ev;
			irq_o       <= |(irq_stat_reg & irq_mask_reg);
			fault_q_reg <= fault_suspend_i;
		end
	end

	// host alert pulse, restarted by any new event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_oe_o    <= 1'b0;
			alert_cnt_reg <= 32'h0;
		end else if (|ev) begin
			alert_oe_o    <= 1'b1;
			alert_cnt_reg <= 32'(ALERT_CYCLES - 1);
		end else if (alert_oe_o) begin
			alert_cnt_reg <= alert_cnt_reg - 32'h1;
			if (alert_cnt_reg == 32'h0)
				alert_oe_o <= 1'b0;
		end
	end

	// status pin: blink on fault, low while charging, else released
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_reg    <= 32'h0;
			blink_phase_reg  <= 1'b0;
			charge_stat_oe_o <= 1'b0;
		end else begin
			if (!fault_suspend_i || blink_cnt_reg == 32'h0)
				blink_cnt_reg <= 32'(BLINK_HALF_CYCLES - 1);
			else
				blink_cnt_reg <= blink_cnt_reg - 32'h1;
			if (!fault_suspend_i)
				blink_phase_reg <= 1'b1;
			else if (blink_cnt_reg == 32'h0)
				blink_phase_reg <= !blink_phase_reg;
			if (fault_suspend_i)
				charge_stat_oe_o <= blink_phase_reg;
			else
				charge_stat_oe_o <= charge_active_i;
		end
	end

	// enable gating and input limit choice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boost_en_o    <= 1'b0;
			charge_en_o   <= 1'b0;
			input_limit_o <= charger_pkg::LIMIT_RESET;
		end else begin
			boost_en_o  <= ctrl_reg[charger_pkg::CTRL_BOOST_BIT] &&
				pin_reg[PIN_BOOST];
			charge_en_o <= ctrl_reg[charger_pkg::CTRL_CHARGE_BIT] &&
				!pin_reg[PIN_CE];
			if (ctrl_reg[charger_pkg::CTRL_LIMPIN_BIT] &&
				input_limit_pin_i >= charger_pkg::PIN_LIMIT_MIN)
				input_limit_o <= min6(input_limit_field_reg,
					input_limit_pin_i);
			else
				input_limit_o <= input_limit_field_reg;
		end
	end

	// button hold timing, ship mode and system power reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			btn_cnt_reg      <= 32'h0;
			btn_used_reg     <= 1'b0;
			ship_reg         <= 1'b0;
			off_reg          <= 1'b0;
			off_cnt_reg      <= 32'h0;
			battery_switch_o <= 1'b1;
		end else begin
			if (pin_reg[PIN_BTN]) begin
				btn_cnt_reg  <= 32'h0;
				btn_used_reg <= 1'b0;
			end else if (btn_cnt_reg != 32'hFFFFFFFF) begin
				btn_cnt_reg <= btn_cnt_reg + 32'h1;
			end
			if (ship_reg && !pin_reg[PIN_BTN] &&
				btn_cnt_reg >= 32'(SHIP_EXIT_CYCLES - 1)) begin
				ship_reg     <= 1'b0;
				btn_used_reg <= 1'b1;
			end else if (wr_hit && address_i == charger_pkg::OFS_CTRL &&
				writedata_i[charger_pkg::CTRL_SHIP_BIT]) begin
				ship_reg <= 1'b1;
			end
			if (ev[charger_pkg::EV_SYSRST]) begin
				off_reg      <= 1'b1;
				off_cnt_reg  <= 32'(SWITCH_OFF_CYCLES - 1);
				btn_used_reg <= 1'b1;
			end else if (off_reg) begin
				off_cnt_reg <= off_cnt_reg - 32'h1;
				if (off_cnt_reg == 32'h0)
					off_reg <= 1'b0;
			end
			battery_switch_o <= !ship_reg && !off_reg;
		end
	end

	// source detection sequence, one step per finished phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_reg    <= charger_pkg::DET_IDLE;
			kind_reg   <= charger_pkg::KIND_SDP;
			vbus_q_reg <= 1'b0;
		end else begin
			vbus_q_reg <= pin_reg[PIN_VB];
			if (!pin_reg[PIN_VB]) begin
				det_reg <= charger_pkg::DET_IDLE;
			end else begin
				case (det_reg)
					charger_pkg::DET_IDLE:
						if (!vbus_q_reg)
							det_reg <= charger_pkg::DET_DCD;
					charger_pkg::DET_DCD:
						if (phase_done_i)
							det_reg <= charger_pkg::DET_PRI;
					charger_pkg::DET_PRI:
						if (phase_done_i)
							det_reg <= charger_pkg::DET_SEC;
					charger_pkg::DET_SEC:
						if (phase_done_i)
							det_reg <= charger_pkg::DET_HV;
					charger_pkg::DET_HV:
						if (phase_done_i) begin
							det_reg  <= charger_pkg::DET_DONE;
							kind_reg <= port_kind_i;
						end
					charger_pkg::DET_DONE: ;
					default:
						det_reg <= charger_pkg::DET_IDLE;
				endcase
			end
		end
	end

	// mux select and data line drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_mux_select_o    <= 1'b0;
			dplus_drive_level_o  <= 3'h0;
			dminus_drive_level_o <= 3'h0;
			dplus_oe_o           <= 1'b0;
			dminus_oe_o          <= 1'b0;
		end else begin
			if (det_reg == charger_pkg::DET_DONE)
				line_mux_select_o <= kind_reg == charger_pkg::KIND_DCP ||
					kind_reg == charger_pkg::KIND_HV_DCP;
			else
				line_mux_select_o <= det_reg != charger_pkg::DET_IDLE;
			dplus_drive_level_o  <= dplus_level_reg;
			dminus_drive_level_o <= dminus_level_reg;
			dplus_oe_o  <= (dplus_level_reg != 3'h0) &&
				(det_reg == charger_pkg::DET_DONE || boost_en_o);
			dminus_oe_o <= (dminus_level_reg != 3'h0) &&
				(det_reg == charger_pkg::DET_DONE || boost_en_o);
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_stat_low;
		charge_active_i && !fault_suspend_i |=> charge_stat_oe_o;
	endproperty
	a_stat_low: assert property (p_stat_low)
		else $error("status pin not low while charging");
	property p_stat_rel;
		!charge_active_i && !fault_suspend_i |=> !charge_stat_oe_o;
	endproperty
	a_stat_rel: assert property (p_stat_rel)
		else $error("status pin not released");
	property p_blink;
		fault_suspend_i && blink_cnt_reg != 32'h0 &&
			$past(fault_suspend_i) |=> $stable(blink_phase_reg);
	endproperty
	a_blink: assert property (p_blink)
		else $error("blink phase changed mid half period");
	property p_alert;
		$rose(alert_oe_o) |-> alert_cnt_reg == 32'(ALERT_CYCLES - 1);
	endproperty
	a_alert: assert property (p_alert)
		else $error("alert pulse length wrong");
	property p_boost;
		boost_en_o |-> $past(ctrl_reg[charger_pkg::CTRL_BOOST_BIT]) &&
			$past(pin_reg[PIN_BOOST]);
	endproperty
	a_boost: assert property (p_boost)
		else $error("boost without both enables");
	property p_charge;
		charge_en_o |-> $past(ctrl_reg[charger_pkg::CTRL_CHARGE_BIT]) &&
			!$past(pin_reg[PIN_CE]);
	endproperty
	a_charge: assert property (p_charge)
		else $error("charging without both enables");
	property p_limit;
		##1 input_limit_o <= $past(input_limit_field_reg);
	endproperty
	a_limit: assert property (p_limit)
		else $error("applied limit above field");
	property p_ship;
		ship_reg && !pin_reg[PIN_BTN] &&
			btn_cnt_reg >= 32'(SHIP_EXIT_CYCLES - 1) |=> ##1 battery_switch_o;
	endproperty
	a_ship: assert property (p_ship)
		else $error("ship mode not left after hold");
	property p_sysrst;
		ev[charger_pkg::EV_SYSRST] |=> ##1 !battery_switch_o [*2];
	endproperty
	a_sysrst: assert property (p_sysrst)
		else $error("switch not opened on system reset");
	property p_mux;
		det_reg == charger_pkg::DET_PRI |=> line_mux_select_o;
	endproperty
	a_mux: assert property (p_mux)
		else $error("mux select low during detection");
	property p_drive;
		dplus_oe_o |-> $past(det_reg == charger_pkg::DET_DONE || boost_en_o);
	endproperty
	a_drive: assert property (p_drive)
		else $error("data pin driven too early");

	c_blink: cover property (fault_suspend_i && $rose(charge_stat_oe_o));
	c_det:   cover property (det_reg == charger_pkg::DET_DONE &&
		line_mux_select_o);
	c_rst:   cover property ($fell(off_reg));
	c_irq:   cover property ($rose(irq_o));
endmodule
`default_nettype wire

// *** tb/charger_far_side.sv ***
// far side model: button, supply and host pins, open drain pull-ups
`timescale 1ns/1ns
`default_nettype none
module charger_far_side (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench commands
	input  wire logic       press_i,
	input  wire logic       boost_req_i,
	input  wire logic       chg_allow_i,
	input  wire logic       vbus_i,
	// open drain enables from the device
	input  wire logic       stat_oe_i,
	input  wire logic       alert_oe_i,
	// pins toward the device
	output logic            battery_button_n_o,
	output logic            boost_request_pin_o,
	output logic            charge_allow_n_o,
	output logic            vbus_present_o,
	// resolved lines and host view
	output logic            stat_line_o,
	output logic            alert_line_o,
	output logic [7:0]      alert_count_o
);
	logic alert_prev;
	// pins follow the commands, button idles high through its pull-up
	assign battery_button_n_o  = !press_i;
	assign boost_request_pin_o = boost_req_i;
	assign charge_allow_n_o    = !chg_allow_i;
	assign vbus_present_o      = vbus_i;
	// pull-ups on the open drain lines
	assign stat_line_o         = !stat_oe_i;
	assign alert_line_o        = !alert_oe_i;
	// host counts falling edges of the alert line
	always_ff @(posedge clk_i) begin
		alert_prev <= alert_line_o;
		if (rst_i) begin
			alert_count_o <= 8'h00;
		end else if (alert_prev && !alert_line_o) begin
			alert_count_o <= alert_count_o + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** tb/charger_pin_control_logic_tb.sv ***
// self-checking bench for the charger pin control logic
`timescale 1ns/1ns
`default_nettype none
module charger_pin_control_logic_tb;
	localparam int ALERT_N = 8;
	localparam int BLINK_N = 8;
	localparam int SHIP_N  = 16;
	localparam int SYSR_N  = 32;
	localparam int OFF_N   = 8;
	logic        clk_i, rst_i, read_i, write_i, waitrequest_o, irq_o;
	logic [4:0]  address_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic        battery_button_n_i, boost_request_pin_i, charge_allow_n_i;
	logic        vbus_present_i, charge_active_i, fault_suspend_i;
	logic        status_event_i, phase_done_i;
	logic [5:0]  input_limit_pin_i, input_limit_o, e;
	logic [2:0]  port_kind_i, dplus_drive_level_o, dminus_drive_level_o;
	logic        charge_stat_oe_o, alert_oe_o, boost_en_o, charge_en_o;
	logic        battery_switch_o, line_mux_select_o, dplus_oe_o;
	logic        dminus_oe_o, press, boost_req, chg_allow, vbus;
	logic        stat_line, alert_line;
	logic [7:0]  alert_count;
	int          errors, tests_run, n;
	logic [5:0]  lf [5] = '{6'h14, 6'h14, 6'h14, 6'h14, 6'h05};
	logic [5:0]  lp [5] = '{6'h0C, 6'h09, 6'h0A, 6'h0C, 6'h0C};
	logic [4:0]  lu     = 5'b10111;
	charger_pkg::det_state_t seq [5] = '{charger_pkg::DET_DCD,
		charger_pkg::DET_PRI, charger_pkg::DET_SEC, charger_pkg::DET_HV,
		charger_pkg::DET_DONE};

	// device with shortened hold and pulse counts
	charger_pin_ctrl #(.ALERT_CYCLES(ALERT_N), .BLINK_HALF_CYCLES(BLINK_N),
		.SHIP_EXIT_CYCLES(SHIP_N), .SYS_RESET_CYCLES(SYSR_N),
		.SWITCH_OFF_CYCLES(OFF_N)) i_dut (.clk_i, .rst_i, .address_i,
		.read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o, .irq_o,
		.battery_button_n_i, .boost_request_pin_i, .charge_allow_n_i,
		.vbus_present_i, .charge_active_i, .fault_suspend_i, .status_event_i,
		.input_limit_pin_i, .phase_done_i, .port_kind_i, .charge_stat_oe_o,
		.alert_oe_o, .boost_en_o, .charge_en_o, .input_limit_o,
		.battery_switch_o, .line_mux_select_o, .dplus_drive_level_o,
		.dplus_oe_o, .dminus_drive_level_o, .dminus_oe_o);
	// button, supply pins and host alert watcher
	charger_far_side i_far (.clk_i, .rst_i, .press_i(press),
		.boost_req_i(boost_req), .chg_allow_i(chg_allow), .vbus_i(vbus),
		.stat_oe_i(charge_stat_oe_o), .alert_oe_i(alert_oe_o),
		.battery_button_n_o(battery_button_n_i),
		.boost_request_pin_o(boost_request_pin_i),
		.charge_allow_n_o(charge_allow_n_i), .vbus_present_o(vbus_present_i),
		.stat_line_o(stat_line), .alert_line_o(alert_line),
		.alert_count_o(alert_count));

	// clock, 20 ns period
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = !clk_i;
	end

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		address_i   <= a;
		writedata_i <= d;
		read_i      <= !wr;
		write_i     <= wr;
		do begin
			@(posedge clk_i);
			k++;
		end while (waitrequest_o !== 1'b0 && k < 20);
		r = readdata_o;
		if (waitrequest_o !== 1'b0) begin
			chk(waitrequest_o, 1'b0);
			close_out();
		end
		read_i  <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] x);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, x);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return charge_stat_oe_o;
			1: return alert_oe_o;
			default: return battery_switch_o;
		endcase
	endfunction
	// wait for a level, then count the cycles it lasts
	task automatic run(input int s, input logic lv, output int c);
		int k;
		k = 0;
		c = 0;
		while (sig(s) !== lv && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		while (sig(s) === lv && c < 2000) begin
			@(posedge clk_i);
			c++;
		end
		if (k >= 2000 || c >= 2000) begin
			chk(c, k);
			close_out();
		end
	endtask
	task automatic event_pulse();
		status_event_i <= 1'b1;
		@(posedge clk_i);
		status_event_i <= 1'b0;
	endtask

	// main sequence
	initial begin
		{rst_i, read_i, write_i, address_i, writedata_i} = '0;
		{press, boost_req, chg_allow, vbus, charge_active_i} = '0;
		{fault_suspend_i, status_event_i, phase_done_i, port_kind_i} = '0;
		input_limit_pin_i = 6'h0C;
		errors = 0;
		tests_run = 0;
		rst_i = 1'b1;
		cyc(12);
		rst_i <= 1'b0;
		cyc(1);
		// reset values and unmapped places
		chk(input_limit_o, 6'h0A);
		chk(battery_switch_o, 1'b1);
		rd(charger_pkg::OFS_CTRL, 32'h5);
		rd(charger_pkg::OFS_LIMIT, 32'h0A);
		rd(charger_pkg::OFS_IRQ_MASK, 32'h0);
		wr(5'h1C, 32'hFFFF_FFFF);
		rd(5'h1C, 32'h0);
		$display("test registers ended");
		// alert pulse, interrupt raise, clear and mask
		wr(charger_pkg::OFS_IRQ_MASK, 32'h1);
		event_pulse();
		run(1, 1'b1, n);
		chk(n, ALERT_N);
		chk(alert_count, 8'h01);
		chk(irq_o, 1'b1);
		rd(charger_pkg::OFS_IRQ_STAT, 32'h1);
		wr(charger_pkg::OFS_IRQ_STAT, 32'h1);
		cyc(2);
		chk(irq_o, 1'b0);
		wr(charger_pkg::OFS_IRQ_MASK, 32'h0);
		event_pulse();
		cyc(3);
		chk(irq_o, 1'b0);
		wr(charger_pkg::OFS_IRQ_STAT, 32'h1F);
		$display("test alert ended");
		// status pin: charging, fault blink, idle
		charge_active_i <= 1'b1;
		cyc(3);
		chk(stat_line, 1'b0);
		cyc(20);
		chk(charge_stat_oe_o, 1'b1);
		fault_suspend_i <= 1'b1;
		run(0, 1'b1, n);
		run(0, 1'b0, n);
		chk(n, BLINK_N);
		run(0, 1'b1, n);
		chk(n, BLINK_N);
		{fault_suspend_i, charge_active_i} <= 2'b00;
		cyc(3);
		chk(stat_line, 1'b1);
		rd(charger_pkg::OFS_IRQ_STAT, 32'h2);
		wr(charger_pkg::OFS_IRQ_STAT, 32'h1F);
		$display("test status pin ended");
		// enables from register bits and pins, data drivers in boost
		wr(charger_pkg::OFS_DRIVE, 32'h35);
		for (int i = 0; i < 16; i++) begin
			chg_allow <= i[1];
			boost_req <= i[3];
			wr(charger_pkg::OFS_CTRL, {28'h0, 1'b0, 1'b1, i[2], i[0]});
			cyc(8);
			chk(charge_en_o, i[0] & i[1]);
			chk(boost_en_o, i[2] & i[3]);
			chk(dplus_oe_o, i[2] & i[3]);
			chk(dminus_oe_o, i[2] & i[3]);
		end
		chk(dminus_drive_level_o, 3'h3);
		{chg_allow, boost_req} <= 2'b00;
		$display("test enables ended");
		// applied input limit
		for (int j = 0; j < 5; j++) begin
			input_limit_pin_i <= lp[j];
			wr(charger_pkg::OFS_LIMIT, lf[j]);
			wr(charger_pkg::OFS_CTRL, {29'h0, lu[j], 2'b01});
			cyc(4);
			e = (lu[j] && lp[j] >= 6'h0A && lp[j] < lf[j]) ? lp[j] : lf[j];
			chk(input_limit_o, e);
		end
		$display("test input limit ended");
		// source detection for every port kind
		for (int k = 0; k < 5; k++) begin
			port_kind_i <= 3'(k);
			vbus <= 1'b1;
			cyc(8);
			chk(line_mux_select_o, 1'b1);
			chk(dplus_oe_o, 1'b0);
			for (int j = 0; j < 5; j++) begin
				bus(1'b0, charger_pkg::OFS_STATUS, 32'h0, q);
				chk(q[6:4], seq[j]);
				if (j < 4) begin
					phase_done_i <= 1'b1;
					@(posedge clk_i);
					phase_done_i <= 1'b0;
				end
			end
			cyc(2);
			chk(line_mux_select_o, k == 2 || k == 3);
			chk(dplus_oe_o, 1'b1);
			chk(dplus_drive_level_o, 3'h5);
			vbus <= 1'b0;
			cyc(8);
			chk(line_mux_select_o, 1'b0);
		end
		$display("test detection ended");
		// ship mode: short press stays, long press leaves
		wr(charger_pkg::OFS_CTRL, 32'h0D);
		cyc(4);
		chk(battery_switch_o, 1'b0);
		press <= 1'b1;
		cyc(SHIP_N / 2);
		press <= 1'b0;
		cyc(8);
		chk(battery_switch_o, 1'b0);
		press <= 1'b1;
		cyc(SHIP_N + 8);
		press <= 1'b0;
		cyc(2);
		chk(battery_switch_o, 1'b1);
		rd(charger_pkg::OFS_CTRL, 32'h5);
		$display("test ship mode ended");
		// long press without supply resets system power
		cyc(8);
		press <= 1'b1;
		cyc(SYSR_N / 2);
		chk(battery_switch_o, 1'b1);
		run(2, 1'b0, n);
		chk(n, OFF_N);
		press <= 1'b0;
		cyc(4);
		chk(battery_switch_o, 1'b1);
		rd(charger_pkg::OFS_IRQ_STAT, 32'h18);
		$display("test system reset ended");
		close_out();
	end
endmodule
`default_nettype wire
